// file: resonant_ctrl_fault_sequencer.sv
/*
 Operating-state sequencer of a resonant converter controller, with an
 AHB-Lite register slave. Assumes comparator flags arrive asynchronously
 from analog blocks and a single-slave AHB-Lite bus on the same clock.
*/
`timescale 1ns/1ps

// Overview of operation
// - Feedback below skip level blocks first start
// - Overload or short stops all but feedback and fault logic
// - After overload, run startup source self-supply
// - Recovery timer counts delay before restart
// - Delay expiry turns startup source on
// - Supply-start opens both blanking windows together
// - Restart passes startup phase then soft-start
// - Supply start biases bulk, feedback, fault, PFC
// - Faults ignored during supply blanking window
// - Overvoltage at blank end keeps drives off
// - Overvoltage cleared: recharge supply for restart
// - Drives only after blanking and no fault
// - Skip: only feedback and supply stay biased
// - Skip exit re-enables blocks and drives
// - No startup source on skip exit
// - Each skip burst opens temperature blanking window
// - Supply below stop in skip: off-mode
// - Bulk loss in burst: self-supply, wait
// - PFC control on while awaiting bulk good
// - Bulk good then supply start: full startup
// - Latching input enters latch-off with self-supply
// - Latch clears only below supply clear level
module resonant_ctrl_fault_sequencer #(
   parameter logic [31:0] SUPPLY_BLANK_CYC = seq_pkg::SUPPLY_BLANK_CYC,
   parameter logic [31:0] LF_BLANK_CYC = seq_pkg::LF_BLANK_CYC,
   parameter logic [31:0] STARTUP_CYC = seq_pkg::STARTUP_CYC,
   parameter logic [31:0] SOFTSTART_CYC = seq_pkg::SOFTSTART_CYC,
   parameter logic [31:0] RECOVERY_CYC = seq_pkg::RECOVERY_CYC
) (
   // Clock and reset
   input wire logic clock,
   input wire logic sys_rst,
   // Comparator flags, asynchronous
   input wire logic startup_source_input,  // High-voltage input biased
   input wire logic supply_start_level,    // Supply above start level
   input wire logic supply_stop_level,     // Supply above stop level
   input wire logic supply_clear_level,    // Supply above clear level
   input wire logic bulk_good,             // Bulk above bulk_threshold
   input wire logic skip_entry_level,      // Feedback below skip entry
   input wire logic skip_exit_level,       // Feedback above skip exit
   input wire logic overload,              // Overload detected
   input wire logic short_circuit,         // Output short detected
   input wire logic latching_fault_input,  // Latching protection input
   // Power stage controls
   output logic gate_drive_enable,
   output logic startup_source_on,
   output logic self_supply_mode,
   output logic pfc_control_output,
   output logic startup_phase,
   output logic soft_start,
   // Block bias enables
   output logic bias_bulk_monitor,
   output logic bias_feedback,
   output logic bias_latch_fault,
   output logic bias_fault_logic,
   output logic bias_main,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp
);
   // ==========================================================
   // Input synchroniser
   // ==========================================================
   localparam int NIN = 10;         // Number of comparator flags
   localparam int I_HV = 0;
   localparam int I_VON = 1;
   localparam int I_VOFF = 2;
   localparam int I_VCLR = 3;
   localparam int I_BULK = 4;
   localparam int I_SKIN = 5;
   localparam int I_SKOUT = 6;
   localparam int I_OVL = 7;
   localparam int I_SHORT = 8;
   localparam int I_LATCH = 9;

   logic [NIN-1:0] raw_in;          // Packed raw flags
   logic [NIN-1:0] meta_r;          // First stage, read by second only
   logic [NIN-1:0] sync_r;          // Second stage, safe to use

   assign raw_in = {latching_fault_input, short_circuit, overload,
                    skip_exit_level, skip_entry_level, bulk_good,
                    supply_clear_level, supply_stop_level,
                    supply_start_level, startup_source_input};

   // Two flops per flag before any logic reads it
   genvar gi;
   generate
      for (gi = 0; gi < NIN; gi = gi + 1) begin : g_sync
         always_ff @(posedge clock) begin
            if (sys_rst) begin
               meta_r[gi] <= 1'b0;
               sync_r[gi] <= 1'b0;
            end else begin
               meta_r[gi] <= raw_in[gi];
               sync_r[gi] <= meta_r[gi];
            end
         end
      end
   endgenerate

   // ==========================================================
   // Register file state
   // ==========================================================
   logic [31:0] ctrl_r;             // Control register
   logic [31:0] ctrl_nxt;
   logic start_inhibit;             // Software start block

   assign start_inhibit = ctrl_r[seq_pkg::CTRL_INHIBIT_BIT];

   // ==========================================================
   // Sequencer state machine
   // ==========================================================
   seq_pkg::seq_state_t state_r;    // Current state
   seq_pkg::seq_state_t state_nxt;
   logic [31:0] cnt_r;              // Phase timer, counts down
   logic [31:0] cnt_nxt;
   logic [31:0] lfb_r;              // Latching-fault blank timer
   logic [31:0] lfb_nxt;
   logic soft_r;                    // Soft-start part of startup
   logic soft_nxt;
   logic lf_masked;                 // Latching fault blanked
   logic power_fault;               // Overload or short
   logic blocked;                   // Start condition not met

   assign lf_masked = (lfb_r != 32'h00000000);
   assign power_fault = sync_r[I_OVL] | sync_r[I_SHORT];
   // Bulk low, skip, overvoltage, start inhibit or a power fault blocks a start
   assign blocked = ~sync_r[I_BULK] | sync_r[I_SKIN]
                    | sync_r[I_LATCH] | start_inhibit
                    | power_fault;

   // Next state, timers and soft-start flag
   always_comb begin
      state_nxt = state_r;
      cnt_nxt = (cnt_r != 32'h00000000) ? cnt_r - 32'h00000001 : cnt_r;
      lfb_nxt = lf_masked ? lfb_r - 32'h00000001 : lfb_r;
      soft_nxt = soft_r;
      case (state_r)
         seq_pkg::ST_OFF: begin
            // Wait for the high-voltage input to come up
            if (sync_r[I_HV]) begin
               state_nxt = seq_pkg::ST_CHARGE;
            end
         end
         seq_pkg::ST_CHARGE: begin
            // Source charges supply up to start level
            if (sync_r[I_VON]) begin
               state_nxt = seq_pkg::ST_BLANK;
               cnt_nxt = SUPPLY_BLANK_CYC;
               lfb_nxt = LF_BLANK_CYC;
            end
         end
         seq_pkg::ST_BLANK: begin
            // Faults not looked at until the window ends
            if (cnt_r == 32'h00000000) begin
               if (blocked) begin
                  state_nxt = seq_pkg::ST_BO_WAIT;
               end else begin
                  state_nxt = seq_pkg::ST_STARTUP;
                  cnt_nxt = STARTUP_CYC;
                  soft_nxt = 1'b0;
               end
            end
         end
         seq_pkg::ST_STARTUP, seq_pkg::ST_RUN: begin
            // Fault priority: latch, power, bulk, stop, skip
            if (sync_r[I_LATCH] && !lf_masked) begin
               state_nxt = seq_pkg::ST_LATCHED;
            end else if (power_fault) begin
               state_nxt = seq_pkg::ST_AREC;
               cnt_nxt = RECOVERY_CYC;
            end else if (!sync_r[I_BULK]) begin
               state_nxt = seq_pkg::ST_BO_WAIT;
            end else if (!sync_r[I_VOFF]) begin
               state_nxt = seq_pkg::ST_OFF;
            end else if (state_r == seq_pkg::ST_STARTUP) begin
               // Startup phase, then soft-start, then run
               if (cnt_r == 32'h00000000) begin
                  if (!soft_r) begin
                     soft_nxt = 1'b1;
                     cnt_nxt = SOFTSTART_CYC;
                  end else begin
                     soft_nxt = 1'b0;
                     state_nxt = seq_pkg::ST_RUN;
                  end
               end
            end else if (sync_r[I_SKIN]) begin
               state_nxt = seq_pkg::ST_SKIP;
            end
         end
         seq_pkg::ST_SKIP: begin
            // Idle between bursts, supply from auxiliary winding
            if (!sync_r[I_VOFF]) begin
               state_nxt = seq_pkg::ST_OFF;
            end else if (sync_r[I_SKOUT]) begin
               state_nxt = seq_pkg::ST_RUN;
               lfb_nxt = LF_BLANK_CYC;
            end
         end
         seq_pkg::ST_BO_WAIT: begin
            // Hold in self-supply until start is allowed again
            if (!blocked) begin
               state_nxt = seq_pkg::ST_CHARGE;
            end
         end
         seq_pkg::ST_AREC: begin
            // Recovery delay, then recharge for restart
            if (cnt_r == 32'h00000000) begin
               state_nxt = seq_pkg::ST_CHARGE;
            end
         end
         seq_pkg::ST_LATCHED: begin
            // Left only through the supply clear check below
            state_nxt = seq_pkg::ST_LATCHED;
         end
         default: begin
            state_nxt = seq_pkg::ST_OFF;
         end
      endcase
      // Supply below clear level resets every state
      if (!sync_r[I_VCLR] && state_r != seq_pkg::ST_OFF) begin
         state_nxt = seq_pkg::ST_OFF;
      end
   end

   // State registers
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         state_r <= seq_pkg::ST_OFF;
         cnt_r <= 32'h00000000;
         lfb_r <= 32'h00000000;
         soft_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
         lfb_r <= lfb_nxt;
         soft_r <= soft_nxt;
      end
   end

   // ==========================================================
   // Output decode
   // ==========================================================
   logic drive_nxt;
   logic source_nxt;
   logic self_nxt;
   logic pfc_nxt;
   logic sphase_nxt;
   logic bulkb_nxt;
   logic fbb_nxt;
   logic lfb_bias_nxt;
   logic faultb_nxt;
   logic mainb_nxt;

   // Outputs follow the next state so they align with state_r
   always_comb begin
      drive_nxt = 1'b0;
      source_nxt = 1'b0;
      self_nxt = 1'b0;
      pfc_nxt = 1'b0;
      sphase_nxt = 1'b0;
      bulkb_nxt = 1'b0;
      fbb_nxt = 1'b0;
      lfb_bias_nxt = 1'b0;
      faultb_nxt = 1'b0;
      mainb_nxt = 1'b0;
      case (state_nxt)
         seq_pkg::ST_OFF: begin
            // Everything unbiased
            drive_nxt = 1'b0;
         end
         seq_pkg::ST_CHARGE: begin
            // Startup source charges the supply
            source_nxt = 1'b1;
         end
         seq_pkg::ST_BLANK: begin
            // All blocks biased, drives still off
            bulkb_nxt = 1'b1;
            fbb_nxt = 1'b1;
            lfb_bias_nxt = 1'b1;
            pfc_nxt = 1'b1;
            faultb_nxt = 1'b1;
            mainb_nxt = 1'b1;
         end
         seq_pkg::ST_STARTUP, seq_pkg::ST_RUN: begin
            // Switching; no startup source here
            drive_nxt = 1'b1;
            sphase_nxt = (state_nxt == seq_pkg::ST_STARTUP) & ~soft_nxt;
            bulkb_nxt = 1'b1;
            fbb_nxt = 1'b1;
            lfb_bias_nxt = 1'b1;
            pfc_nxt = 1'b1;
            faultb_nxt = 1'b1;
            mainb_nxt = 1'b1;
            source_nxt = 1'b0;
         end
         seq_pkg::ST_SKIP: begin
            // Only feedback and supply management stay up
            fbb_nxt = 1'b1;
         end
         seq_pkg::ST_BO_WAIT: begin
            // Bulk monitored, PFC asked to refill bulk
            self_nxt = 1'b1;
            source_nxt = ~sync_r[I_VON];
            bulkb_nxt = 1'b1;
            fbb_nxt = 1'b1;
            faultb_nxt = 1'b1;
            mainb_nxt = 1'b1;
            pfc_nxt = 1'b1;
         end
         seq_pkg::ST_AREC: begin
            // Feedback and fault logic on self-supply
            self_nxt = 1'b1;
            source_nxt = ~sync_r[I_VON];
            fbb_nxt = 1'b1;
            faultb_nxt = 1'b1;
         end
         seq_pkg::ST_LATCHED: begin
            // Latch held by self-supply, feedback only
            self_nxt = 1'b1;
            source_nxt = ~sync_r[I_VON];
            fbb_nxt = 1'b1;
         end
         default: begin
            drive_nxt = 1'b0;
         end
      endcase
   end

   // Output registers
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         gate_drive_enable <= 1'b0;
         startup_source_on <= 1'b0;
         self_supply_mode <= 1'b0;
         pfc_control_output <= 1'b0;
         startup_phase <= 1'b0;
         soft_start <= 1'b0;
         bias_bulk_monitor <= 1'b0;
         bias_feedback <= 1'b0;
         bias_latch_fault <= 1'b0;
         bias_fault_logic <= 1'b0;
         bias_main <= 1'b0;
      end else begin
         gate_drive_enable <= drive_nxt;
         startup_source_on <= source_nxt;
         self_supply_mode <= self_nxt;
         pfc_control_output <= pfc_nxt;
         startup_phase <= sphase_nxt;
         soft_start <= (state_nxt == seq_pkg::ST_STARTUP) & soft_nxt;
         bias_bulk_monitor <= bulkb_nxt;
         bias_feedback <= fbb_nxt;
         bias_latch_fault <= lfb_bias_nxt;
         bias_fault_logic <= faultb_nxt;
         bias_main <= mainb_nxt;
      end
   end

   // ==========================================================
   // AHB-Lite slave
   // ==========================================================
   // Offset match on the word address
   function automatic logic hit(input logic [31:0] a,
                                input logic [11:0] ofs);
      hit = (a[11:2] == ofs[11:2]);
   endfunction

   logic wr_pend_r;                 // Write data phase pending
   logic wr_pend_nxt;
   logic [31:0] wr_addr_r;          // Address of pending write
   logic [31:0] wr_addr_nxt;
   logic [31:0] rdata_nxt;
   logic [31:0] status_word;        // Live status image
   logic take;                      // Valid address phase

   assign take = hsel & hready & htrans[1];

   always_comb begin
      status_word = 32'h00000000;
      status_word[seq_pkg::ST_STATE_LSB +: 4] = state_r;
      status_word[seq_pkg::ST_DRIVE_BIT] = gate_drive_enable;
      status_word[seq_pkg::ST_SOURCE_BIT] = startup_source_on;
      status_word[seq_pkg::ST_SELF_BIT] = self_supply_mode;
      status_word[seq_pkg::ST_PFC_BIT] = pfc_control_output;
      status_word[seq_pkg::ST_STARTUP_BIT] = startup_phase;
      status_word[seq_pkg::ST_SOFT_BIT] = soft_start;
      status_word[seq_pkg::ST_LFBLANK_BIT] = lf_masked;
      status_word[seq_pkg::ST_SBLANK_BIT] =
         (state_r == seq_pkg::ST_BLANK);
   end

   // Address phase capture, write completion, read data
   always_comb begin
      wr_pend_nxt = take & hwrite;
      wr_addr_nxt = take ? haddr : wr_addr_r;
      ctrl_nxt = ctrl_r;
      rdata_nxt = hrdata;
      if (wr_pend_r && hit(wr_addr_r, seq_pkg::CTRL_OFS)) begin
         ctrl_nxt = {31'h00000000, hwdata[seq_pkg::CTRL_INHIBIT_BIT]};
      end
      if (take && !hwrite) begin
         if (hit(haddr, seq_pkg::CTRL_OFS)) begin
            rdata_nxt = ctrl_r;
         end else if (hit(haddr, seq_pkg::STATUS_OFS)) begin
            rdata_nxt = status_word;
         end else if (hit(haddr, seq_pkg::INPUTS_OFS)) begin
            rdata_nxt = {{(32-NIN){1'b0}}, sync_r};
         end else begin
            rdata_nxt = 32'h00000000;
         end
      end
   end

   // Bus registers
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         wr_pend_r <= 1'b0;
         wr_addr_r <= 32'h00000000;
         ctrl_r <= seq_pkg::CTRL_RST;
         hrdata <= 32'h00000000;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         wr_pend_r <= wr_pend_nxt;
         wr_addr_r <= wr_addr_nxt;
         ctrl_r <= ctrl_nxt;
         hrdata <= rdata_nxt;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end
endmodule

// file: resonant_ctrl_fault_sequencer_tb.sv
/* Testbench of the fault sequencer.
 Assumes the stage model and the checker alongside. */
`timescale 1ns/1ps
module resonant_ctrl_fault_sequencer_tb;
   logic clock = 0, sys_rst = 1, startup_source_input = 0, bulk_good = 1;
   logic skip_entry_level = 0, skip_exit_level = 0, overload = 0;
   logic short_circuit = 0, latching_fault_input = 0, hsel = 0, hwrite = 0;
   logic [31:0] haddr = 0, hwdata = 0, hrdata, d;
   logic [1:0] htrans = 0;
   logic [2:0] hsize = 3'h2;
   logic supply_start_level, supply_stop_level, supply_clear_level;
   logic gate_drive_enable, startup_source_on, self_supply_mode, hreadyout;
   logic pfc_control_output, startup_phase, soft_start, hresp;
   logic bias_bulk_monitor, bias_feedback, bias_latch_fault;
   logic bias_fault_logic, bias_main;
   int num_errors = 0, checks_done = 0, cycles = 0;
   // Device with short durations
   resonant_ctrl_fault_sequencer #(.SUPPLY_BLANK_CYC(32'h8),
      .LF_BLANK_CYC(32'hA), .STARTUP_CYC(32'h5), .SOFTSTART_CYC(32'hA),
      .RECOVERY_CYC(32'h14)) resonant_ctrl_fault_sequencer_i (
      .hready(hreadyout), .*);
   stage_model stage_model_i (.line_on(startup_source_input), .*);
   always #25 clock = ~clock;
   // Hang guard
   always @(posedge clock) begin
      cycles++;
      if (cycles == 20000) begin
         num_errors++;
         test_done();
      end
   end
   task test_done();
      if (num_errors == 0 && checks_done > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         num_errors++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // Single AHB-Lite transfer
   task bus(input logic w, input logic [11:0] a, input logic [31:0] wd,
         output logic [31:0] rd);
      hsel <= 1'b1;
      haddr <= {20'h0, a};
      hwrite <= w;
      htrans <= 2'h2;
      do @(posedge clock); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge clock); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask
   // Poll state code, bounded
   task wait_st(input logic [3:0] s);
      int n;
      n = 0;
      d = '1;
      while (d[3:0] !== s && n < 500) begin
         bus(1'b0, seq_pkg::STATUS_OFS, 32'h0, d);
         n++;
      end
      check({28'h0, d[3:0]}, {28'h0, s});
   endtask
   initial begin
      repeat (2) @(posedge clock);
      sys_rst <= 1'b0;
      @(posedge clock);
      bus(1'b1, seq_pkg::CTRL_OFS, 32'h1, d);
      bus(1'b0, seq_pkg::CTRL_OFS, 32'h0, d);
      check(d, 32'h1);
      bus(1'b0, 12'h00C, 32'h0, d);
      check(d, 32'h0);
      check(32'(hresp), 32'h0);
      bus(1'b1, seq_pkg::CTRL_OFS, 32'h0, d);
      skip_entry_level <= 1'b1;
      startup_source_input <= 1'b1;
      wait_st(4'h6);
      bus(1'b1, seq_pkg::CTRL_OFS, 32'h1, d);
      skip_entry_level <= 1'b0;
      repeat (4) bus(1'b0, seq_pkg::STATUS_OFS, 32'h0, d);
      check({28'h0, d[3:0]}, 32'h6);
      bus(1'b1, seq_pkg::CTRL_OFS, 32'h0, d);
      wait_st(4'h2);
      check(32'(d[11:10]), 32'h3);
      wait_st(4'h3);
      check({startup_phase, soft_start}, 2'h2);
      wait_st(4'h4);
      skip_entry_level <= 1'b1;
      wait_st(4'h5);
      check({gate_drive_enable, bias_main, bias_feedback}, 3'h1);
      skip_entry_level <= 1'b0;
      skip_exit_level <= 1'b1;
      wait_st(4'h4);
      check(32'(d[10]), 32'h1);
      check({gate_drive_enable, startup_source_on}, 2'h2);
      skip_exit_level <= 1'b0;
      for (int i = 0; i < 2; i++) begin
         {short_circuit, overload} <= 2'(1 << i);
         wait_st(4'h7);
         check({gate_drive_enable, self_supply_mode, bias_fault_logic,
            bias_main}, 4'h6);
         {short_circuit, overload} <= 2'h0;
         wait_st(4'h3);
         wait_st(4'h4);
      end
      overload <= 1'b1;
      wait_st(4'h7);
      {overload, latching_fault_input} <= 2'h1;
      wait_st(4'h6);
      check(32'(gate_drive_enable), 32'h0);
      latching_fault_input <= 1'b0;
      wait_st(4'h3);
      wait_st(4'h4);
      bulk_good <= 1'b0;
      wait_st(4'h6);
      check({pfc_control_output, bias_latch_fault, bias_bulk_monitor},
         3'h5);
      bulk_good <= 1'b1;
      wait_st(4'h3);
      wait_st(4'h4);
      latching_fault_input <= 1'b1;
      wait_st(4'h8);
      check({gate_drive_enable, bias_feedback}, 2'h1);
      latching_fault_input <= 1'b0;
      startup_source_input <= 1'b0;
      wait_st(4'h0);
      test_done();
   end
endmodule

// file: seq_asserts.sv
/* Checker of sequencer outputs.
 Assumes binding to the sequencer top. */
`timescale 1ns/1ps
module seq_chk (
   // Watched ports
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic supply_start_level,
   input wire logic supply_stop_level,
   input wire logic supply_clear_level,
   input wire logic overload,
   input wire logic gate_drive_enable,
   input wire logic startup_source_on,
   input wire logic self_supply_mode,
   input wire logic pfc_control_output,
   input wire logic startup_phase,
   input wire logic soft_start,
   input wire logic bias_bulk_monitor,
   input wire logic bias_feedback,
   input wire logic bias_latch_fault,
   input wire logic bias_main
);
   default clocking @(posedge clock); endclocking
   default disable iff (sys_rst);
   // Inputs held through synchroniser and state
   sequence ovl_held; overload[*4]; endsequence
   sequence stop_low; !supply_stop_level[*4]; endsequence
   sequence clear_low; !supply_clear_level[*4]; endsequence
   soft_after_start_a: assert property (
      $rose(soft_start) |-> $past(startup_phase))
      else $error("soft start without startup phase");
   overload_stop_a: assert property (
      ovl_held |-> !gate_drive_enable)
      else $error("drive on during overload");
   stop_off_a: assert property (
      stop_low |-> !gate_drive_enable)
      else $error("drive on below stop level");
   clear_off_a: assert property (
      clear_low |-> !bias_feedback && !gate_drive_enable)
      else $error("not off below clear level");
   source_drive_a: assert property (
      startup_source_on |-> !gate_drive_enable)
      else $error("source on while driving");
   self_supply_a: assert property (
      supply_start_level[*4] ##0 self_supply_mode |-> !startup_source_on)
      else $error("source on with supply high");
   drive_bias_a: assert property (
      $rose(gate_drive_enable) |-> bias_main && bias_feedback)
      else $error("drive without biased blocks");
   start_bias_a: assert property (
      $rose(bias_latch_fault) |->
         bias_bulk_monitor && bias_feedback && pfc_control_output)
      else $error("start blocks not biased together");
endmodule
bind resonant_ctrl_fault_sequencer seq_chk seq_chk_i (.*);

// file: seq_pkg.sv
/*
 Shared constants for the resonant converter fault sequencer: register
 offsets and fields, reset values, state codes and timing counts.
 Assumes a 20 MHz system clock and a 32-bit AHB-Lite register bus.
*/
package seq_pkg;
   // =========================================================
   // Clock
   // =========================================================
   localparam int CLK_PERIOD_NS = 50;     // 20 MHz

   // =========================================================
   // Timing, printed unit then derived cycle count (round up)
   // =========================================================
   localparam int SUPPLY_BLANK_US = 20;   // Supply blanking window
   localparam int LF_BLANK_US = 50;       // Latching-fault blanking
   localparam int STARTUP_US = 10;        // Dedicated startup phase
   localparam int SOFTSTART_US = 2000;    // Soft-start ramp
   localparam int RECOVERY_DELAY_MS = 1000; // Auto-recovery delay
   localparam logic [31:0] SUPPLY_BLANK_CYC =
      32'((SUPPLY_BLANK_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [31:0] LF_BLANK_CYC =
      32'((LF_BLANK_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [31:0] STARTUP_CYC =
      32'((STARTUP_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [31:0] SOFTSTART_CYC =
      32'((SOFTSTART_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [31:0] RECOVERY_CYC =
      32'((RECOVERY_DELAY_MS * 1000000 + CLK_PERIOD_NS - 1)
          / CLK_PERIOD_NS);

   // =========================================================
   // Register map (byte addresses)
   // =========================================================
   localparam logic [11:0] CTRL_OFS = 12'h000;    // Control
   localparam logic [11:0] STATUS_OFS = 12'h004;  // Sequencer status
   localparam logic [11:0] INPUTS_OFS = 12'h008;  // Synced inputs
   localparam logic [31:0] CTRL_RST = 32'h00000000;
   localparam int CTRL_INHIBIT_BIT = 0;   // Start inhibit
   localparam int ST_STATE_LSB = 0;       // State code [3:0]
   localparam int ST_DRIVE_BIT = 4;
   localparam int ST_SOURCE_BIT = 5;
   localparam int ST_SELF_BIT = 6;
   localparam int ST_PFC_BIT = 7;
   localparam int ST_STARTUP_BIT = 8;
   localparam int ST_SOFT_BIT = 9;
   localparam int ST_LFBLANK_BIT = 10;
   localparam int ST_SBLANK_BIT = 11;

   // =========================================================
   // Sequencer states
   // =========================================================
   typedef enum logic [3:0] {
      ST_OFF      = 4'h0,
      ST_CHARGE   = 4'h1,
      ST_BLANK    = 4'h2,
      ST_STARTUP  = 4'h3,
      ST_RUN      = 4'h4,
      ST_SKIP     = 4'h5,
      ST_BO_WAIT  = 4'h6,
      ST_AREC     = 4'h7,
      ST_LATCHED  = 4'h8
   } seq_state_t;
endpackage

// file: stage_model.sv
/* Power stage and supply comparator model.
 Assumes one clock shared with the sequencer. */
`timescale 1ns/1ps
module stage_model (
   // Clock
   input wire logic clock,
   // Controls
   input wire logic startup_source_on,
   input wire logic line_on,
   // Supply comparator flags
   output logic supply_start_level,
   output logic supply_stop_level,
   output logic supply_clear_level
);
   // ==========
   // Supply
   // ==========
   int vcc = 0; // Supply level in steps
   // Source charges from the line, unplugged line drains
   always @(posedge clock) begin
      if (startup_source_on && line_on && vcc < 100) begin
         vcc <= vcc + 1;
      end else if (!line_on && vcc > 0) begin
         vcc <= vcc - 1;
      end
   end
   assign supply_start_level = (vcc >= 60);
   assign supply_stop_level = (vcc >= 40);
   assign supply_clear_level = (vcc >= 10);
endmodule
